/* logic/pcmsap_params.svh */
`ifndef PCMSAP_PARAMS_SVH
`define PCMSAP_PARAMS_SVH

// register byte offsets
`define PCMSAP_OFS_CTRL     8'h00
`define PCMSAP_OFS_SLOT     8'h04
`define PCMSAP_OFS_FMT      8'h08
`define PCMSAP_OFS_STAT     8'h0C
`define PCMSAP_OFS_TXD0     8'h10
`define PCMSAP_OFS_RXD0     8'h20
`define PCMSAP_OFS_STRIDE   8'h04

// reset values
`define PCMSAP_CTRL_RST     7'h00
`define PCMSAP_SLOT_RST     15'h0000
`define PCMSAP_FMT_RST      8'h00

// clocking
`define PCMSAP_CORE_KHZ     64'd100000
`define PCMSAP_BCLK0_KHZ    64'd128
`define PCMSAP_BCLK1_KHZ    64'd512
`define PCMSAP_BCLK2_KHZ    64'd1024
`define PCMSAP_NCO_W        24
`define PCMSAP_NCO_INC(k)   24'((k * 64'h1000000) / `PCMSAP_CORE_KHZ)

// frame geometry
`define PCMSAP_SLOT_BITS_LOG 4
`define PCMSAP_SLOT_LAST    4'hF
`define PCMSAP_SAMPLE_W     13
`define PCMSAP_PAD_W        3
`define PCMSAP_LONG_SYNC    8'h03
`define PCMSAP_LOG_128K     3'h0
`define PCMSAP_LOG_512K     3'h2
`define PCMSAP_LOG_1024K    3'h3

// pad fill modes
`define PCMSAP_PAD_ZERO     2'h0
`define PCMSAP_PAD_ONES     2'h1
`define PCMSAP_PAD_SIGN     2'h2
`define PCMSAP_PAD_CONST    2'h3

`endif

/* logic/pcmsap_pkg.sv */
package pcmsap_pkg;
    typedef struct packed {
        logic       i2sOwn;
        logic       fs16;
        logic [1:0] rateSel;
        logic       longSync;
        logic       master;
        logic       enable;
    } pcmsap_ctrl_s;

    typedef struct packed {
        logic [2:0] padConst;
        logic [1:0] padMode;
        logic       lsbFirst;
        logic [1:0] shift;
    } pcmsap_fmt_s;

    typedef struct packed {
        logic [2:0]  chEn;
        logic [11:0] chSlot;
    } pcmsap_slot_s;
endpackage

/* logic/pcmsap_top.sv */
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "pcmsap_params.svh"

// Function
// - role is master or slave, chosen by a control bit.
// - master drives bit clock and sync; slave takes both as inputs.
// - when the shared pins belong to I2S, every pin driver is off.
// - three full-duplex channels share the one serial link.
// - a frame at 8 or 16 kHz splits into slots, eight at most.
// - slot count follows the bit clock rate of 128, 512 or 1024 kHz.
// - a channel sends and receives in the same slot.
// - data output floats in every slot that no enabled channel owns.
// - output releases after the falling clock edge of the slot's last bit.
// - short or long sync, each usable as master or slave.
// - short sync is one bit wide, high in the bit before slot zero.
// - slave short sync seen on a fall starts bit zero at next rise.
// - long sync is three bits wide, starting with bit zero.
// - each 16-bit slot word carries a 13-bit sample plus padding.
// - sample position and bit order in the word are programmable.
// - pad bits dropped on receive; sent as zeros, ones, sign or constant.
// - reset format is left justified two's complement, MSB first.
module pcmsap_top
    import pcmsap_pkg::*;
#(
    parameter int NUM_CH = 3
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        resetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // bit clock pin
    input  wire logic        pcmClkIn,
    output logic             pcmClkOut,
    output logic             pcmClkOe,
    // frame sync pin
    input  wire logic        pcmSyncIn,
    output logic             pcmSyncOut,
    output logic             pcmSyncOe,
    // data pins
    input  wire logic        pcmDin,
    output logic             pcmDout,
    output logic             pcmDoutOe,
    // status
    output logic             portActive
);
    localparam int SW = `PCMSAP_SAMPLE_W;

    pcmsap_ctrl_s ctrl_r;
    pcmsap_fmt_s  fmt_r;
    pcmsap_slot_s slot_r;
    logic [SW-1:0]     txData_r [NUM_CH];
    logic [SW-1:0]     rxData_r [NUM_CH];
    logic [NUM_CH-1:0] rxFresh_r;
    logic [7:0]        frameCnt_r;
    logic [31:0]       prdata_r;
    logic              pslverr_r;

    // pin synchronisers
    logic clkS1, clkS2, syncS1, syncS2, dinS1, dinS2;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            {clkS1, clkS2, syncS1, syncS2, dinS1, dinS2} <= 6'h00;
        end else begin
            {clkS1, syncS1, dinS1} <= {pcmClkIn, pcmSyncIn, pcmDin};
            {clkS2, syncS2, dinS2} <= {clkS1, syncS1, dinS1};
        end
    end

    // port gating: shared pins go to I2S whenever it claims them
    wire active = ctrl_r.enable & ~ctrl_r.i2sOwn;
    wire master = ctrl_r.master;

    // master bit clock from a phase accumulator, so 128 kHz needs no integer divide
    wire [23:0] ncoInc = (ctrl_r.rateSel == 2'h0) ? `PCMSAP_NCO_INC(`PCMSAP_BCLK0_KHZ) :
                         (ctrl_r.rateSel == 2'h1) ? `PCMSAP_NCO_INC(`PCMSAP_BCLK1_KHZ) :
                                                    `PCMSAP_NCO_INC(`PCMSAP_BCLK2_KHZ);
    logic [`PCMSAP_NCO_W-1:0] nco_r;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            nco_r <= '0;
        else if (active && master)
            nco_r <= nco_r + ncoInc;
        else
            nco_r <= '0;
    end

    // unified edge events for both roles
    wire bclk = master ? nco_r[`PCMSAP_NCO_W-1] : clkS2;
    logic bclkD_r;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            bclkD_r <= 1'b0;
        else
            bclkD_r <= bclk;
    end
    wire riseEv = active & bclk & ~bclkD_r;
    wire fallEv = active & ~bclk & bclkD_r;

    // frame geometry from rate and frame rate
    wire [2:0] rateLog = (ctrl_r.rateSel == 2'h0) ? `PCMSAP_LOG_128K :
                         (ctrl_r.rateSel == 2'h1) ? `PCMSAP_LOG_512K : `PCMSAP_LOG_1024K;
    // 128 kHz at 16 kHz is below one slot; clamped to one slot
    wire [2:0] slotLog = (ctrl_r.fs16 && rateLog != 3'h0) ? rateLog - 3'h1 : rateLog;
    wire [4:0] numSlots = 5'h01 << slotLog;
    wire [7:0] lastBit  = 8'((9'h010 << slotLog) - 9'h001);

    // bit counter and slave resync
    logic [7:0] bitCnt_r;
    logic       armed_r, syncFall_r;
    wire        slaveShort = ~master & ~ctrl_r.longSync;
    wire [7:0]  nb = (armed_r || bitCnt_r >= lastBit) ? 8'h00 : bitCnt_r + 8'h01;
    wire        longStart = ~master & ctrl_r.longSync & syncS2 & ~syncFall_r;
    // a long sync that lands off bit zero moves the counter under a driven slot
    wire        longJump  = fallEv & longStart & (bitCnt_r != 8'h00);
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            bitCnt_r   <= 8'h00;
            armed_r    <= 1'b0;
            syncFall_r <= 1'b0;
        end else if (!active) begin
            bitCnt_r   <= 8'h00;
            armed_r    <= 1'b0;
            syncFall_r <= 1'b0;
        end else if (riseEv) begin
            bitCnt_r <= nb;
            armed_r  <= 1'b0;
        end else if (fallEv) begin
            syncFall_r <= syncS2;
            armed_r    <= slaveShort & syncS2;
            if (longStart)
                bitCnt_r <= 8'h00;
        end
    end

    // master sync generation, updated on rising edges
    logic syncOut_r;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            syncOut_r <= 1'b0;
        else if (!active || !master)
            syncOut_r <= 1'b0;
        else if (riseEv) begin
            // a pulse only starts at bit zero, so a mode switch mid-frame
            // cannot emit a long sync that begins late
            if (ctrl_r.longSync)
                syncOut_r <= (nb == 8'h00) | (syncOut_r & (nb < `PCMSAP_LONG_SYNC));
            else
                syncOut_r <= nb == lastBit;
        end
    end

    // slot ownership, same map used for transmit and receive
    wire [3:0] nbSlot  = nb[7:4];
    wire [3:0] curSlot = bitCnt_r[7:4];
    wire [3:0] curPos  = bitCnt_r[3:0];
    logic [NUM_CH-1:0] ownNb, ownCur;
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            wire [3:0] chSlot = slot_r.chSlot[4*g +: 4];
            assign ownNb[g]  = slot_r.chEn[g] & (chSlot == nbSlot) & ({1'b0, chSlot} < numSlots);
            assign ownCur[g] = slot_r.chEn[g] & (chSlot == curSlot) & ({1'b0, chSlot} < numSlots);
        end
    endgenerate

    // transmit word build: {sample, pad} rotated right by shift
    logic [SW-1:0] txSample;
    always_comb begin
        txSample = '0;
        for (int i = NUM_CH - 1; i >= 0; i--)
            if (ownNb[i])
                txSample = txData_r[i];
    end
    wire [2:0] padBits = (fmt_r.padMode == `PCMSAP_PAD_ZERO)  ? 3'h0 :
                         (fmt_r.padMode == `PCMSAP_PAD_ONES)  ? 3'h7 :
                         (fmt_r.padMode == `PCMSAP_PAD_SIGN)  ? {3{txSample[SW-1]}} :
                                                                fmt_r.padConst;
    wire [15:0] txRaw  = {txSample, padBits};
    wire [31:0] txDbl  = {txRaw, txRaw} >> fmt_r.shift;
    wire [15:0] txWord = txDbl[15:0];
    wire [3:0]  nbPos  = nb[3:0];
    wire [3:0]  txIdx  = fmt_r.lsbFirst ? nbPos : `PCMSAP_SLOT_LAST - nbPos;

    logic dout_r, doutOe_r;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            dout_r   <= 1'b0;
            doutOe_r <= 1'b0;
        end else if (!active) begin
            doutOe_r <= 1'b0;
        end else if (riseEv) begin
            dout_r   <= txWord[txIdx];
            doutOe_r <= |ownNb;
        end else if (fallEv && curPos == `PCMSAP_SLOT_LAST) begin
            doutOe_r <= 1'b0;
        end else if (longJump) begin
            doutOe_r <= 1'b0;
        end
    end

    // receive: capture on falling edges, un-rotate, drop pad bits
    logic [15:0] rxWord_r;
    logic [15:0] rxCur;
    wire  [3:0]  rxIdx = fmt_r.lsbFirst ? curPos : `PCMSAP_SLOT_LAST - curPos;
    always_comb begin
        rxCur        = rxWord_r;
        rxCur[rxIdx] = dinS2;
    end
    wire [31:0] rxDbl    = {rxCur, rxCur} << fmt_r.shift;
    wire [SW-1:0] rxSamp = rxDbl[31:32-SW];
    wire slotEnd = fallEv & (curPos == `PCMSAP_SLOT_LAST);

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            rxWord_r <= 16'h0000;
        else if (fallEv)
            rxWord_r <= rxCur;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            frameCnt_r <= 8'h00;
        else if (riseEv && nb == 8'h00)
            frameCnt_r <= frameCnt_r + 8'h01;
    end

    // apb decode
    wire        setup   = psel & ~penable;
    wire        access  = psel & penable;
    wire [7:0]  wOfs    = paddr - `PCMSAP_OFS_TXD0;
    wire [7:0]  rOfs    = paddr - `PCMSAP_OFS_RXD0;
    wire        isTx    = paddr >= `PCMSAP_OFS_TXD0 && wOfs < 8'(NUM_CH * 4) && paddr[1:0] == 2'h0;
    wire        isRx    = paddr >= `PCMSAP_OFS_RXD0 && rOfs < 8'(NUM_CH * 4) && paddr[1:0] == 2'h0;
    wire [1:0]  txSel   = wOfs[3:2];
    wire [1:0]  rxSel   = rOfs[3:2];
    wire        isCtrl  = paddr == `PCMSAP_OFS_CTRL;
    wire        isSlot  = paddr == `PCMSAP_OFS_SLOT;
    wire        isFmt   = paddr == `PCMSAP_OFS_FMT;
    wire        isStat  = paddr == `PCMSAP_OFS_STAT;
    wire        mapped  = isCtrl | isSlot | isFmt | isStat | isTx | isRx;
    wire        wrEn    = access & pwrite & mapped;
    wire [31:0] rdMux   = isCtrl ? {25'h0, ctrl_r} :
                          isSlot ? {17'h0, slot_r} :
                          isFmt  ? {24'h0, fmt_r} :
                          isStat ? {15'h0, active, frameCnt_r, 5'h0, rxFresh_r} :
                          isTx   ? {19'h0, txData_r[txSel]} :
                          isRx   ? {19'h0, rxData_r[rxSel]} : 32'h0;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_r <= `PCMSAP_CTRL_RST;
            slot_r <= `PCMSAP_SLOT_RST;
            fmt_r  <= `PCMSAP_FMT_RST;
        end else if (wrEn) begin
            if (isCtrl)
                ctrl_r <= pwdata[6:0];
            if (isSlot)
                slot_r <= pwdata[14:0];
            if (isFmt)
                fmt_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            prdata_r  <= 32'h0;
            pslverr_r <= 1'b0;
        end else if (setup) begin
            prdata_r  <= pwrite ? 32'h0 : rdMux;
            pslverr_r <= ~mapped;
        end
    end

    generate
        for (g = 0; g < NUM_CH; g++) begin : g_data
            always_ff @(posedge core_clk or negedge resetn) begin
                if (!resetn) begin
                    txData_r[g]  <= '0;
                    rxData_r[g]  <= '0;
                    rxFresh_r[g] <= 1'b0;
                end else begin
                    if (wrEn && isTx && txSel == 2'(g))
                        txData_r[g] <= pwdata[SW-1:0];
                    if (slotEnd && ownCur[g])
                        rxData_r[g] <= rxSamp;
                    // a new sample wins over a clear in the same cycle
                    if (slotEnd && ownCur[g])
                        rxFresh_r[g] <= 1'b1;
                    else if (wrEn && isStat && pwdata[g])
                        rxFresh_r[g] <= 1'b0;
                end
            end
        end
    endgenerate

    assign prdata     = prdata_r;
    assign pslverr    = access & pslverr_r;
    assign pready     = 1'b1;
    assign pcmClkOut  = nco_r[`PCMSAP_NCO_W-1];
    assign pcmClkOe   = active & master;
    assign pcmSyncOut = syncOut_r;
    assign pcmSyncOe  = active & master;
    assign pcmDout    = dout_r;
    assign pcmDoutOe  = doutOe_r & active;
    assign portActive = active;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    property p_slave_inputs; !master |-> !pcmClkOe && !pcmSyncOe; endproperty
    a_slave_inputs: assert property (p_slave_inputs) else $error("slave drives clock or sync");
    property p_master_drives; active && master |-> pcmClkOe && pcmSyncOe; endproperty
    a_master_drives: assert property (p_master_drives) else $error("master not driving");
    property p_i2s_off; ctrl_r.i2sOwn |-> !pcmClkOe && !pcmSyncOe && !pcmDoutOe; endproperty
    a_i2s_off: assert property (p_i2s_off) else $error("driver on while I2S owns pins");
    property p_unused_float; pcmDoutOe |-> |ownCur; endproperty
    a_unused_float: assert property (p_unused_float) else $error("output on unowned slot");
    property p_release; slotEnd |=> !pcmDoutOe; endproperty
    a_release: assert property (p_release) else $error("no release after last bit");
    property p_short_sync; master && !ctrl_r.longSync && $rose(pcmSyncOut) |->
        bitCnt_r == lastBit ##1 !riseEv [*1]; endproperty
    a_short_sync: assert property (p_short_sync) else $error("short sync misplaced");
    property p_long_sync; master && ctrl_r.longSync && $rose(pcmSyncOut) |-> bitCnt_r == 8'h00;
    endproperty
    a_long_sync: assert property (p_long_sync) else $error("long sync not at bit zero");
    property p_slave_start; riseEv && armed_r |=> bitCnt_r == 8'h00; endproperty
    a_slave_start: assert property (p_slave_start) else $error("slave bit zero late");
    property p_launch; active && $changed(dout_r) |-> $past(riseEv); endproperty
    a_launch: assert property (p_launch) else $error("data changed off rising edge");
    property p_geometry; ctrl_r.rateSel == 2'h0 && !ctrl_r.fs16 |-> lastBit == 8'h0F;
    endproperty
    a_geometry: assert property (p_geometry) else $error("slot count wrong for rate");
    property p_reset_fmt; $rose(resetn) |-> fmt_r.shift == 2'h0 && !fmt_r.lsbFirst; endproperty
    a_reset_fmt: assert property (p_reset_fmt) else $error("reset format wrong");

    c_master_frame: cover property (master && riseEv && nb == 8'h00);
    c_slave_long: cover property (longStart && fallEv);
    c_rx_sample: cover property (slotEnd && |ownCur);
endmodule

/* sim/pcmsap_codec_model.sv */
`timescale 1ns/1ns

// far-side bus master: makes bit clock and sync only while run is high,
// drives one 16-bit slot word and captures the port's slot word
module pcmsap_codec_model (
    // control from the bench
    input  wire logic        run,
    input  wire logic        longSync,
    input  wire logic [6:0]  frameBits,
    input  wire logic [1:0]  slotSel,
    input  wire logic [15:0] txWord,
    // wire from the port under test
    input  wire logic        doutWire,
    // link outputs
    output logic             bclk,
    output logic             sync,
    output logic             din,
    // observation
    output logic [15:0]      rxWord,
    output logic [6:0]       bitIdx,
    output int               frames
);
    int         b;
    logic       inSlot;
    logic [15:0] rx;

    initial begin
        bclk = 1'b0;
        sync = 1'b0;
        din = 1'b0;
        rxWord = 16'h0000;
        bitIdx = 7'h00;
        frames = 0;
        rx = 16'h0000;
    end

    // clock stands still between bursts; phase unrelated to the core clock
    always begin
        wait (run);
        #7;
        b = int'(frameBits) - 1;
        while (run) begin
            bitIdx = 7'(b);
            bclk = 1'b1;
            sync = longSync ? (b < 3) : (b == int'(frameBits) - 1);
            inSlot = (b / 16) == int'(slotSel);
            // outside our slot the line shows no stale value
            din = inSlot ? txWord[15 - b % 16] : ~din;
            #80;
            bclk = 1'b0;
            if (inSlot) rx[15 - b % 16] = doutWire;
            if (b == int'(frameBits) - 1) begin
                rxWord = rx;
                frames++;
            end
            #80;
            b = (b + 1) % int'(frameBits);
        end
        sync = 1'b0;
    end
endmodule

/* sim/test_pcm_slot_audio_port.sv */
`timescale 1ns/1ns
`include "pcmsap_params.svh"
`define CHK(got, exp) begin nCompared++; if ((got) !== (exp)) begin miscompares++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); end end

module test_pcm_slot_audio_port import pcmsap_pkg::*;;
    logic core_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdData, seed = 32'd70, rv;
    logic pready, pslverr, rdErr, pcmClkOut, pcmClkOe, pcmSyncOut, pcmSyncOe;
    logic pcmDout, pcmDoutOe, portActive, mClk, mSync, mDin, doutHold = 1'b0, pc;
    logic run = 1'b0, mLong = 1'b0;
    logic [6:0]  mBits = 7'd16, mIdx;
    logic [1:0]  mSlot = 2'h0;
    logic [15:0] mTx = 16'h0000, mRx;
    logic [63:0] oeMask, fm;
    logic [12:0] sample;
    int mFrames, miscompares = 0, nCompared = 0, ch, slot, k, h, f0, r;
    pcmsap_ctrl_s ctrl;
    pcmsap_fmt_s  fmt;
    pcmsap_slot_s sl;
    logic [1:0] rateTab [4] = '{2'h0, 2'h1, 2'h1, 2'h2};
    logic       fsTab [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    logic [6:0] bitsTab [4] = '{7'd16, 7'd64, 7'd32, 7'd64};

    always #5 core_clk = ~core_clk;

    // each pin resolves to whichever side enables its driver
    wire clkPin = pcmClkOe ? pcmClkOut : mClk;
    wire syncPin = pcmSyncOe ? pcmSyncOut : mSync;
    wire doutWire = pcmDoutOe ? pcmDout : ~doutHold;
    always @(posedge core_clk) if (pcmDoutOe) doutHold <= pcmDout;
    always @(negedge mClk) if (run) oeMask[mIdx] <= pcmDoutOe;

    pcmsap_top DUT (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pcmClkIn(clkPin), .pcmClkOut(pcmClkOut), .pcmClkOe(pcmClkOe),
        .pcmSyncIn(syncPin), .pcmSyncOut(pcmSyncOut), .pcmSyncOe(pcmSyncOe), .pcmDin(mDin),
        .pcmDout(pcmDout), .pcmDoutOe(pcmDoutOe), .portActive(portActive));

    pcmsap_codec_model codec (.run(run), .longSync(mLong), .frameBits(mBits),
        .slotSel(mSlot), .txWord(mTx), .doutWire(doutWire), .bclk(mClk), .sync(mSync),
        .din(mDin), .rxWord(mRx), .bitIdx(mIdx), .frames(mFrames));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [15:0] rev16(input logic [15:0] w);
        for (int i = 0; i < 16; i++) rev16[i] = w[15 - i];
    endfunction

    // slot word as it appears on the wire, first bit in [15]
    function automatic logic [15:0] txWire(input logic [12:0] s, input pcmsap_fmt_s f);
        logic [2:0]  p;
        logic [31:0] dbl;
        p = (f.padMode == `PCMSAP_PAD_ZERO) ? 3'h0 : (f.padMode == `PCMSAP_PAD_ONES) ? 3'h7 :
            (f.padMode == `PCMSAP_PAD_SIGN) ? {3{s[12]}} : f.padConst;
        dbl = {s, p, s, p} >> f.shift;
        return f.lsbFirst ? rev16(dbl[15:0]) : dbl[15:0];
    endfunction

    function automatic logic [12:0] rxSample(input logic [15:0] w, input pcmsap_fmt_s f);
        logic [15:0] u;
        logic [31:0] dbl;
        u = f.lsbFirst ? rev16(w) : w;
        dbl = {u, u} << f.shift;
        return dbl[31:19];
    endfunction

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (n >= 100) begin
            miscompares++;
            $display("unexpected at %0t: no pready", $time);
        end
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic end_sim();
        $display("compared %0d, miscompares %0d", nCompared, miscompares);
        if (miscompares == 0 && nCompared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        #1000000;
        $display("unexpected at %0t: run did not finish", $time);
        miscompares++;
        end_sim();
    end

    initial begin
        repeat (4) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        apb(1'b0, `PCMSAP_OFS_FMT, 32'h0);
        `CHK(rdData[7:0], `PCMSAP_FMT_RST)
        apb(1'b0, `PCMSAP_OFS_SLOT, 32'h0);
        `CHK(rdData[14:0], `PCMSAP_SLOT_RST)
        apb(1'b0, 8'h40, 32'h0);
        `CHK({rdErr, rdData}, 33'h1_0000_0000)
        for (int it = 0; it < 8; it++) begin
            k = it / 2;
            rv = xs();
            ch = int'(rv[31:16] % 3);
            slot = int'(rv[15:8]) % (int'(bitsTab[k]) / 16);
            sample = (it == 0) ? 13'h1000 : 13'(xs());
            fmt = '{rv[2:0], 2'(it), rv[3], rv[5:4]};
            ctrl = '0;
            ctrl.enable = 1'b1;
            ctrl.longSync = rv[6];
            ctrl.rateSel = rateTab[k];
            ctrl.fs16 = fsTab[k];
            sl = '0;
            sl.chEn[ch] = 1'b1;
            sl.chSlot[ch * 4 +: 4] = 4'(slot);
            mTx = 16'(xs());
            mBits <= bitsTab[k];
            mSlot <= 2'(slot);
            mLong <= ctrl.longSync;
            oeMask = '0;
            apb(1'b1, `PCMSAP_OFS_CTRL, 32'(ctrl));
            apb(1'b1, `PCMSAP_OFS_SLOT, 32'(sl));
            apb(1'b1, `PCMSAP_OFS_FMT, 32'(fmt));
            apb(1'b1, 8'(`PCMSAP_OFS_TXD0 + 4 * ch), 32'(sample));
            f0 = mFrames;
            run <= 1'b1;
            wait (mFrames >= f0 + 3);
            @(posedge core_clk);
            run <= 1'b0;
            repeat (30) @(posedge core_clk);
            fm = (bitsTab[k] == 7'd64) ? '1 : ((64'h1 << bitsTab[k]) - 64'h1);
            `CHK(mRx, txWire(sample, fmt))
            `CHK(oeMask & fm, 64'hFFFF << (16 * slot))
            `CHK({pcmClkOe, pcmSyncOe}, 2'b00)
            apb(1'b0, 8'(`PCMSAP_OFS_RXD0 + 4 * ch), 32'h0);
            `CHK(rdData[12:0], rxSample(mTx, fmt))
        end
        for (int l = 0; l < 2; l++) begin
            ctrl = '0;
            ctrl.enable = 1'b1;
            ctrl.master = 1'b1;
            ctrl.longSync = 1'(l);
            apb(1'b1, `PCMSAP_OFS_CTRL, 32'(ctrl));
            // the first pulse after a switch may be cut short
            @(posedge pcmSyncOut);
            @(posedge pcmSyncOut);
            h = 0;
            r = 0;
            pc = pcmClkOut;
            while (pcmSyncOut === 1'b1 && h < 5000) begin
                @(posedge core_clk);
                h++;
                if (pcmClkOut === 1'b1 && pc === 1'b0) r++;
                pc = pcmClkOut;
            end
            `CHK((h + 390) / 781, (l == 1) ? 3 : 1)
            `CHK(r, (l == 1) ? 3 : 1)
            `CHK({pcmClkOe, pcmSyncOe}, 2'b11)
        end
        @(posedge core_clk);
        ctrl.i2sOwn = 1'b1;
        apb(1'b1, `PCMSAP_OFS_CTRL, 32'(ctrl));
        repeat (4) @(posedge core_clk);
        `CHK({pcmClkOe, pcmSyncOe, pcmDoutOe, portActive}, 4'h0)
        end_sim();
    end
endmodule
